// ### inc/tcic_pkg.sv
// ==========================================================================
// Shared constants for the timer counter with input capture.
package tcic_pkg;

  // ========================================================================
  // Sizes.
  localparam int TCIC_NCH = 2;

  // ========================================================================
  // Byte register map.
  localparam logic [7:0] TCIC_ADDR_TSC = 8'h00;
  localparam logic [7:0] TCIC_ADDR_CNT_HI = 8'h01;
  localparam logic [7:0] TCIC_ADDR_CNT_LO = 8'h02;
  localparam logic [7:0] TCIC_ADDR_MOD_HI = 8'h03;
  localparam logic [7:0] TCIC_ADDR_MOD_LO = 8'h04;
  localparam logic [7:0] TCIC_ADDR_CH_BASE = 8'h05;
  localparam logic [7:0] TCIC_ADDR_CH_STRIDE = 8'h03;
  localparam logic [7:0] TCIC_CH_OFS_SC = 8'h00;
  localparam logic [7:0] TCIC_CH_OFS_VH = 8'h01;
  localparam logic [7:0] TCIC_CH_OFS_VL = 8'h02;

  // ========================================================================
  // Field positions of timer_status_control.
  localparam int TCIC_TSC_FLAG = 7;
  localparam int TCIC_TSC_IE = 6;
  localparam int TCIC_TSC_CAS = 5;
  localparam int TCIC_TSC_CSS_LSB = 3;

  // ========================================================================
  // Field positions of channel_status_control.
  localparam int TCIC_CSC_FLAG = 7;
  localparam int TCIC_CSC_IE = 6;
  localparam int TCIC_CSC_MU = 5;
  localparam int TCIC_CSC_ML = 4;
  localparam int TCIC_CSC_EL_LSB = 2;

  // ========================================================================
  // Encodings.
  typedef enum logic [1:0] {
    TCIC_CSS_NONE = 2'h0,
    TCIC_CSS_BUS = 2'h1,
    TCIC_CSS_FIXED = 2'h2,
    TCIC_CSS_EXT = 2'h3
  } tcic_css_t;

  localparam logic [1:0] TCIC_MODE_CAPTURE = 2'h0;
  localparam logic [1:0] TCIC_EL_OFF = 2'h0;
  localparam logic [1:0] TCIC_EL_RISE = 2'h1;
  localparam logic [1:0] TCIC_EL_FALL = 2'h2;
  localparam logic [1:0] TCIC_EL_BOTH = 2'h3;

  // ========================================================================
  // Counter values and reset values.
  localparam logic [15:0] TCIC_CNT_RST = 16'h0000;
  localparam logic [15:0] TCIC_CNT_ONE = 16'h0001;
  localparam logic [15:0] TCIC_TERM_FREE = 16'hffff;
  localparam logic [7:0] TCIC_REG8_RST = 8'h00;

endpackage

// ### design/tcic_sync_edge.sv
`timescale 1ns/10ps
// ==========================================================================
// Two-stage synchroniser with edge pulses taken behind the second stage.
module tcic_sync_edge
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic d_in,
  output logic rise,
  output logic fall
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // ========================================================================
  // The first stage feeds only the second one, so metastability stays put.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else
    begin
      s1_q <= d_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;

endmodule // tcic_sync_edge

// ### design/tcic_timer.sv
`timescale 1ns/10ps
// How it works
// - Clock select 00 stops, 01 bus clock, 10 fixed clock, 11 external pin.
// - Reset leaves the clock select at 00, so the counter is idle.
// - Clock select is always accessible; writing 00 leaves every other register alone.
// - Bus clock source steps the counter every cycle with no synchroniser.
// - Fixed clock equals bus clock unless the loop is engaged, then synchronised.
// - External clock from channel 0 pin always passes a bus-clock synchroniser.
// - Overflow interrupt is a level while flag and enable are both one.
// - Up counting runs 0x0000 to terminal count, then wraps to 0x0000.
// - Free running, the overflow flag sets on 0xFFFF to 0x0000.
// - With a modulus, the overflow flag sets on modulus to 0x0000.
// - Center-aligned counts up to terminal, down to 0x0000, each end one tick.
// - Up/down overflow sets when the count leaves terminal toward the lower value.
// - Any counter byte write zeroes the counter and clears its read latch.
// - With center-aligned off, each channel's mode bits pick its own function.
// - Mode 00 captures, 01 compares, 1X edge PWM; edge field 00 disconnects. Only capture is built; modes 01 and 1X just accept value writes.
// - Edge field 01 rising, 10 falling, 11 both edges for capture.
// - An active capture edge copies the counter into the channel value.
// - Software picks rising, falling or either edge as the capture trigger.
// - In capture mode, channel value writes are ignored.
// - In capture mode outside debug, reading one value byte latches the other for a coherent 16-bit read.
// - Any channel status/control write clears that channel's read latch.
// - A capture sets the channel flag and raises its interrupt when enabled.
// - In background debug capture still works, copying the frozen counter.
module tcic_timer
  import tcic_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [TCIC_NCH-1:0] chan_pin,
  input wire logic xtal_half_clk,
  input wire logic fll_engaged,
  input wire logic debug_active,
  output logic overflow_irq,
  output logic [TCIC_NCH-1:0] channel_irq
);

  // ========================================================================
  // Declarations.
  tcic_css_t css_q;
  logic ovf_flag_q;
  logic ovf_ie_q;
  logic cas_q;
  logic [15:0] cnt_q;
  logic cnt_up_q;
  logic [15:0] mod_q;
  logic cnt_lat_q;
  logic [15:0] cnt_buf_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic ovf_irq_q;
  logic [TCIC_NCH-1:0] ch_irq_q;
  logic [TCIC_NCH-1:0] ch_flag_q;
  logic [TCIC_NCH-1:0] ch_ie_q;
  logic [1:0] ch_mode_q [TCIC_NCH];
  logic [1:0] ch_el_q [TCIC_NCH];
  logic [15:0] ch_val_q [TCIC_NCH];
  logic [TCIC_NCH-1:0] ch_lat_q;
  logic [15:0] ch_buf_q [TCIC_NCH];
  logic [TCIC_NCH-1:0] pin_rise;
  logic [TCIC_NCH-1:0] pin_fall;
  logic [TCIC_NCH-1:0] ch_capmode;
  logic [TCIC_NCH-1:0] ch_capture;
  logic [TCIC_NCH-1:0] sel_sc;
  logic [TCIC_NCH-1:0] sel_vh;
  logic [TCIC_NCH-1:0] sel_vl;
  logic xtal_rise;
  logic src_tick;
  logic tick;
  logic [15:0] term;
  logic wr_tsc;
  logic wr_cnt;
  logic rd_cnt;
  logic ovf_set;

  // ========================================================================
  // Synchronisers. Every pin goes through one, including the clock pin.
  tcic_sync_edge u_xtal_sync
  (
    .clk(clk),
    .nrst(nrst),
    .d_in(xtal_half_clk),
    .rise(xtal_rise),
    .fall()
  );

  // ========================================================================
  // Clock source selection and counter step.
  always_comb
  begin
    unique case (css_q)
      TCIC_CSS_NONE: src_tick = 1'b0;
      TCIC_CSS_BUS: src_tick = 1'b1;
      TCIC_CSS_FIXED: src_tick = fll_engaged ? xtal_rise : 1'b1;
      TCIC_CSS_EXT: src_tick = pin_rise[0];
      default: src_tick = 1'b0;
    endcase
  end

  // The counter is frozen in background debug so captures see a still value.
  assign tick = src_tick & ~debug_active;
  assign term = (mod_q == TCIC_CNT_RST) ? TCIC_TERM_FREE : mod_q;

  assign wr_tsc = wr && (addr == TCIC_ADDR_TSC);
  assign wr_cnt = wr && ((addr == TCIC_ADDR_CNT_HI) || (addr == TCIC_ADDR_CNT_LO));
  assign rd_cnt = rd && ((addr == TCIC_ADDR_CNT_HI) || (addr == TCIC_ADDR_CNT_LO));

  // Overflow at wrap in up mode, at the turn from terminal in up/down mode.
  assign ovf_set = tick && !wr_cnt && (cnt_q == term) && (!cas_q || cnt_up_q);

  // ========================================================================
  // Timer status and control register.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      css_q <= TCIC_CSS_NONE;
      ovf_ie_q <= 1'b0;
      cas_q <= 1'b0;
    end
    else if (wr_tsc)
    begin
      css_q <= tcic_css_t'(wdata[TCIC_TSC_CSS_LSB +: 2]);
      ovf_ie_q <= wdata[TCIC_TSC_IE];
      cas_q <= wdata[TCIC_TSC_CAS];
    end
  end

  // A fresh overflow wins over a clearing write in the same cycle.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ovf_flag_q <= 1'b0;
    end
    else if (ovf_set)
    begin
      ovf_flag_q <= 1'b1;
    end
    else if (wr_tsc && !wdata[TCIC_TSC_FLAG])
    begin
      ovf_flag_q <= 1'b0;
    end
  end

  // ========================================================================
  // Main counter.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q <= TCIC_CNT_RST;
      cnt_up_q <= 1'b1;
    end
    else if (wr_cnt)
    begin
      cnt_q <= TCIC_CNT_RST;
      cnt_up_q <= 1'b1;
    end
    else if (tick)
    begin
      if (!cas_q)
      begin
        cnt_q <= (cnt_q == term) ? TCIC_CNT_RST : cnt_q + TCIC_CNT_ONE;
        cnt_up_q <= 1'b1;
      end
      else if (cnt_up_q)
      begin
        if (cnt_q == term)
        begin
          cnt_q <= cnt_q - TCIC_CNT_ONE;
          cnt_up_q <= 1'b0;
        end
        else
        begin
          cnt_q <= cnt_q + TCIC_CNT_ONE;
        end
      end
      else
      begin
        if (cnt_q == TCIC_CNT_RST)
        begin
          cnt_q <= TCIC_CNT_ONE;
          cnt_up_q <= 1'b1;
        end
        else
        begin
          cnt_q <= cnt_q - TCIC_CNT_ONE;
        end
      end
    end
  end

  // ========================================================================
  // Modulus register, written byte by byte.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mod_q <= TCIC_CNT_RST;
    end
    else if (wr && (addr == TCIC_ADDR_MOD_HI))
    begin
      mod_q[15:8] <= wdata;
    end
    else if (wr && (addr == TCIC_ADDR_MOD_LO))
    begin
      mod_q[7:0] <= wdata;
    end
  end

  // ========================================================================
  // Counter read latch. Reads leave it as it was while debug is active; a counter write still clears it.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_lat_q <= 1'b0;
      cnt_buf_q <= TCIC_CNT_RST;
    end
    else if (wr_cnt)
    begin
      cnt_lat_q <= 1'b0;
    end
    else if (rd_cnt && !debug_active)
    begin
      if (cnt_lat_q)
      begin
        cnt_lat_q <= 1'b0;
      end
      else
      begin
        cnt_lat_q <= 1'b1;
        cnt_buf_q <= cnt_q;
      end
    end
  end

  // ========================================================================
  // Channels.
  for (genvar i = 0; i < TCIC_NCH; i++)
  begin : g_ch
    localparam logic [7:0] BASE = 8'(TCIC_ADDR_CH_BASE + TCIC_ADDR_CH_STRIDE * i);

    tcic_sync_edge u_pin_sync
    (
      .clk(clk),
      .nrst(nrst),
      .d_in(chan_pin[i]),
      .rise(pin_rise[i]),
      .fall(pin_fall[i])
    );

    assign sel_sc[i] = (addr == 8'(BASE + TCIC_CH_OFS_SC));
    assign sel_vh[i] = (addr == 8'(BASE + TCIC_CH_OFS_VH));
    assign sel_vl[i] = (addr == 8'(BASE + TCIC_CH_OFS_VL));

    // Capture only exists while center-aligned mode is off.
    assign ch_capmode[i] = !cas_q && (ch_mode_q[i] == TCIC_MODE_CAPTURE);
    assign ch_capture[i] = ch_capmode[i] &&
      (((ch_el_q[i] == TCIC_EL_RISE) && pin_rise[i]) ||
       ((ch_el_q[i] == TCIC_EL_FALL) && pin_fall[i]) ||
       ((ch_el_q[i] == TCIC_EL_BOTH) && (pin_rise[i] || pin_fall[i])));

    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        ch_ie_q[i] <= 1'b0;
        ch_mode_q[i] <= TCIC_MODE_CAPTURE;
        ch_el_q[i] <= TCIC_EL_OFF;
      end
      else if (wr && sel_sc[i])
      begin
        ch_ie_q[i] <= wdata[TCIC_CSC_IE];
        ch_mode_q[i] <= {wdata[TCIC_CSC_MU], wdata[TCIC_CSC_ML]};
        ch_el_q[i] <= wdata[TCIC_CSC_EL_LSB +: 2];
      end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        ch_flag_q[i] <= 1'b0;
      end
      else if (ch_capture[i])
      begin
        ch_flag_q[i] <= 1'b1;
      end
      else if (wr && sel_sc[i] && !wdata[TCIC_CSC_FLAG])
      begin
        ch_flag_q[i] <= 1'b0;
      end
    end

    // Debug does not stop capture; the counter it copies is simply frozen.
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        ch_val_q[i] <= TCIC_CNT_RST;
      end
      else if (ch_capture[i])
      begin
        ch_val_q[i] <= cnt_q;
      end
      else if (wr && sel_vh[i] && !ch_capmode[i])
      begin
        ch_val_q[i][15:8] <= wdata;
      end
      else if (wr && sel_vl[i] && !ch_capmode[i])
      begin
        ch_val_q[i][7:0] <= wdata;
      end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        ch_lat_q[i] <= 1'b0;
        ch_buf_q[i] <= TCIC_CNT_RST;
      end
      else if (wr && sel_sc[i])
      begin
        ch_lat_q[i] <= 1'b0;
      end
      else if (rd && (sel_vh[i] || sel_vl[i]) && ch_capmode[i] && !debug_active)
      begin
        if (ch_lat_q[i])
        begin
          ch_lat_q[i] <= 1'b0;
        end
        else
        begin
          ch_lat_q[i] <= 1'b1;
          ch_buf_q[i] <= ch_val_q[i];
        end
      end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        ch_irq_q[i] <= 1'b0;
      end
      else
      begin
        ch_irq_q[i] <= ch_flag_q[i] & ch_ie_q[i];
      end
    end
  end

  // ========================================================================
  // Read multiplexer. Debug reads show live values, never the buffers.
  always_comb
  begin
    rdata_d = TCIC_REG8_RST;
    if (addr == TCIC_ADDR_TSC)
    begin
      rdata_d = {ovf_flag_q, ovf_ie_q, cas_q, css_q, 3'h0};
    end
    else if (addr == TCIC_ADDR_CNT_HI)
    begin
      rdata_d = (cnt_lat_q && !debug_active) ? cnt_buf_q[15:8] : cnt_q[15:8];
    end
    else if (addr == TCIC_ADDR_CNT_LO)
    begin
      rdata_d = (cnt_lat_q && !debug_active) ? cnt_buf_q[7:0] : cnt_q[7:0];
    end
    else if (addr == TCIC_ADDR_MOD_HI)
    begin
      rdata_d = mod_q[15:8];
    end
    else if (addr == TCIC_ADDR_MOD_LO)
    begin
      rdata_d = mod_q[7:0];
    end
    for (int k = 0; k < TCIC_NCH; k++)
    begin
      if (sel_sc[k])
      begin
        rdata_d = {ch_flag_q[k], ch_ie_q[k], ch_mode_q[k], ch_el_q[k], 2'h0};
      end
      else if (sel_vh[k])
      begin
        rdata_d = (ch_lat_q[k] && !debug_active) ? ch_buf_q[k][15:8] : ch_val_q[k][15:8];
      end
      else if (sel_vl[k])
      begin
        rdata_d = (ch_lat_q[k] && !debug_active) ? ch_buf_q[k][7:0] : ch_val_q[k][7:0];
      end
    end
  end

  // Data stand only in the cycle after the read strobe.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_q <= TCIC_REG8_RST;
    end
    else
    begin
      rdata_q <= rd ? rdata_d : TCIC_REG8_RST;
    end
  end

  // ========================================================================
  // Overflow request, registered so the output comes from a flip-flop.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ovf_irq_q <= 1'b0;
    end
    else
    begin
      ovf_irq_q <= ovf_flag_q & ovf_ie_q;
    end
  end

  assign rdata = rdata_q;
  assign overflow_irq = ovf_irq_q;
  assign channel_irq = ch_irq_q;

endmodule // tcic_timer

// ### verification/tcic_timer_asserts.sv
`timescale 1ns/10ps
// ==========================================
// Port checks of the timer counter.
module tcic_timer_chk
  import tcic_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [TCIC_NCH-1:0] chan_pin,
  input wire logic xtal_half_clk,
  input wire logic fll_engaged,
  input wire logic debug_active,
  input wire logic overflow_irq,
  input wire logic [TCIC_NCH-1:0] channel_irq
);
  logic ie_q, cas_q, cie_q;
  logic [1:0] css_q, cm_q, el_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Control bits are shadowed here because the ports do not show them.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ie_q <= 1'b0;
      cas_q <= 1'b0;
      css_q <= 2'h0;
    end
    else if (wr && addr == TCIC_ADDR_TSC)
    begin
      ie_q <= wdata[TCIC_TSC_IE];
      cas_q <= wdata[TCIC_TSC_CAS];
      css_q <= wdata[4:3];
    end
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cie_q <= 1'b0;
      cm_q <= 2'h0;
      el_q <= 2'h0;
    end
    else if (wr && addr == TCIC_ADDR_CH_BASE + TCIC_ADDR_CH_STRIDE)
    begin
      cie_q <= wdata[TCIC_CSC_IE];
      cm_q <= wdata[5:4];
      el_q <= wdata[3:2];
    end
  end
  sequence cnt_wr_stop;
    wr && (addr == TCIC_ADDR_CNT_HI || addr == TCIC_ADDR_CNT_LO) && css_q == 2'h0;
  endsequence
  sequence lo_rd_stop;
    rd && addr == TCIC_ADDR_CNT_LO && css_q == 2'h0;
  endsequence
  sequence lo_rd_dbg;
    rd && addr == TCIC_ADDR_CNT_LO && debug_active;
  endsequence
  a_reset_quiet: assert property (
    $rose(nrst) |-> !overflow_irq && channel_irq == '0)
    else $error("irq active right after reset");
  a_ovf_gated: assert property ($rose(overflow_irq) |-> $past(ie_q))
    else $error("overflow irq rose while disabled");
  a_ovf_off: assert property (
    (wr && addr == TCIC_ADDR_TSC && !wdata[TCIC_TSC_IE]) ##1 !(wr && addr == TCIC_ADDR_TSC)
    |-> ##1 !overflow_irq)
    else $error("overflow irq stayed after disable");
  a_cap_gated: assert property ($rose(channel_irq[1]) |-> $past(cie_q))
    else $error("channel irq rose while disabled");
  a_cap_irq: assert property (
    $rose(chan_pin[1]) && !cas_q && cm_q == TCIC_MODE_CAPTURE && el_q[0] && cie_q
    |-> ##[3:6] channel_irq[1])
    else $error("rising edge not captured");
  a_fall_only: assert property (
    $rose(chan_pin[1]) && el_q == TCIC_EL_FALL && !channel_irq[1] |-> !channel_irq[1] [*6])
    else $error("rising edge captured in falling mode");
  a_dbg_frozen: assert property (
    lo_rd_dbg ##1 debug_active ##1 lo_rd_dbg |-> ##1 rdata == $past(rdata, 2))
    else $error("counter moved during debug");
  a_cnt_zero: assert property (cnt_wr_stop ##2 lo_rd_stop |-> ##1 rdata == 8'h00)
    else $error("counter write did not zero the count");
endmodule // tcic_timer_chk

bind tcic_timer tcic_timer_chk chk (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .chan_pin(chan_pin), .xtal_half_clk(xtal_half_clk),
  .fll_engaged(fll_engaged), .debug_active(debug_active), .overflow_irq(overflow_irq),
  .channel_irq(channel_irq));

// ### verification/tcic_pin_model.sv
`timescale 1ns/10ps
// ==========================================
// Far side: external clock on pin 0, events on pin 1.
module tcic_pin_model
  import tcic_pkg::*;
#(
  parameter int HALF = 4
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ext_run,
  input wire logic ev_lvl,
  output logic [TCIC_NCH-1:0] chan_pin
);
  logic pin0_q;
  int cnt;
  // The clock pin stands low outside bursts; HALF of 2 or more keeps a quarter rate.
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst || !ext_run)
    begin
      cnt <= 0;
      pin0_q <= 1'b0;
    end
    else if (cnt == HALF - 1)
    begin
      cnt <= 0;
      pin0_q <= !pin0_q;
    end
    else
      cnt <= cnt + 1;
  end
  assign chan_pin = {ev_lvl, pin0_q};
endmodule // tcic_pin_model

// ### verification/tb.sv
`timescale 1ns/10ps
// ==========================================
// Self-checking bench of the timer counter.
module tb;
  import tcic_pkg::*;
  localparam logic [7:0] tsc = TCIC_ADDR_TSC;
  localparam logic [7:0] cnh = TCIC_ADDR_CNT_HI;
  localparam logic [7:0] cnl = TCIC_ADDR_CNT_LO;
  localparam logic [7:0] mdl = TCIC_ADDR_MOD_LO;
  localparam logic [7:0] sc1 = TCIC_ADDR_CH_BASE + TCIC_ADDR_CH_STRIDE;
  localparam logic [7:0] vh1 = sc1 + TCIC_CH_OFS_VH;
  localparam logic [7:0] vl1 = sc1 + TCIC_CH_OFS_VL;
  logic clk, nrst, wr, rd, xtal_half_clk, fll_engaged, debug_active, ext_run, ev_lvl;
  logic overflow_irq;
  logic [7:0] addr, wdata, rdata;
  logic [TCIC_NCH-1:0] chan_pin, channel_irq;
  int err_count, n_checks;
  tcic_timer uut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .chan_pin(chan_pin), .xtal_half_clk(xtal_half_clk),
    .fll_engaged(fll_engaged), .debug_active(debug_active), .overflow_irq(overflow_irq),
    .channel_irq(channel_irq));
  tcic_pin_model pins (.clk(clk), .nrst(nrst), .ext_run(ext_run), .ev_lvl(ev_lvl),
    .chan_pin(chan_pin));
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Each access leaves an idle cycle so no strobe is set twice in one step.
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
    @(posedge clk);
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    rreg(a, v[15:8]);
    rreg(a + 8'h01, v[7:0]);
  endtask
  task automatic wait_irq(input int lim, output int n);
    n = 0;
    while (overflow_irq !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= lim)
    begin
      err_count++;
      finish_test();
    end
  endtask
  task automatic t_reset();
    logic [7:0] v;
    for (logic [7:0] a = 8'h00; a < 8'h0c; a++)
    begin
      rreg(a, v);
      chk({8'h00, v}, 16'h0000);
    end
    chk({13'h0, overflow_irq, channel_irq}, 16'h0000);
  endtask
  task automatic t_sources();
    logic [1:0] css [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3};
    int lo_b [5] = '{0, 60, 60, 6, 6};
    int hi_b [5] = '{0, 64, 64, 9, 9};
    logic [15:0] v;
    for (int i = 0; i < 5; i++)
    begin
      fll_engaged <= (i == 3);
      ext_run <= (i == 4);
      wreg(cnh, 8'h00);
      wreg(tsc, {3'h0, css[i], 3'h0});
      repeat (60) @(posedge clk);
      wreg(tsc, 8'h00);
      rd16(cnh, v);
      chk({15'h0, v >= lo_b[i] && v <= hi_b[i]}, 16'h1);
    end
    ext_run <= 1'b0;
  endtask
  task automatic t_stop();
    logic [15:0] a, b;
    logic [7:0] v;
    wreg(mdl, 8'h5a);
    wreg(tsc, 8'h08);
    repeat (20) @(posedge clk);
    wreg(tsc, 8'h00);
    rd16(cnh, a);
    repeat (20) @(posedge clk);
    rd16(cnh, b);
    chk(b, a);
    rreg(mdl, v);
    chk({8'h00, v}, 16'h005a);
    rreg(cnh, v);
    wreg(cnl, 8'hff);
    rreg(cnl, v);
    chk({8'h00, v}, 16'h0000);
  endtask
  task automatic t_overflow();
    logic [7:0] v;
    int n;
    wreg(mdl, 8'h10);
    wreg(cnh, 8'h00);
    wreg(tsc, 8'h48);
    wait_irq(40, n);
    chk({15'h0, n >= 15 && n <= 20}, 16'h1);
    wreg(tsc, 8'h48);
    #1;
    chk({15'h0, overflow_irq}, 16'h0);
    wreg(mdl, 8'h00);
    wreg(cnl, 8'h00);
    wait_irq(70000, n);
    chk({15'h0, n >= 65530}, 16'h1);
    wreg(tsc, 8'h88);
    #1;
    chk({15'h0, overflow_irq}, 16'h0);
    rreg(tsc, v);
    chk({8'h00, v}, 16'h0088);
    wreg(tsc, 8'h00);
  endtask
  task automatic t_center();
    logic [15:0] v;
    int n0, n4, bad;
    n0 = 0;
    n4 = 0;
    bad = 0;
    wreg(mdl, 8'h04);
    wreg(cnh, 8'h00);
    wreg(tsc, 8'h68);
    // Five cycles per sample walks every phase of the eight-tick period.
    for (int i = 0; i < 8; i++)
    begin
      rd16(cnh, v);
      @(posedge clk);
      n0 += (v === 16'h0000);
      n4 += (v === 16'h0004);
      bad += ((v > 16'h0004) !== 1'b0);
    end
    chk({15'h0, n0 == 1 && n4 == 1 && bad == 0}, 16'h1);
    chk({15'h0, overflow_irq}, 16'h1);
    wreg(tsc, 8'h00);
  endtask
  task automatic t_capture();
    logic [7:0] v, w;
    logic [15:0] c, p;
    for (logic [2:0] e = 3'h0; e < 3'h4; e++)
    begin
      wreg(sc1, {4'h4, e[1:0], 2'h0});
      ev_lvl <= 1'b1;
      repeat (8) @(posedge clk);
      chk({15'h0, channel_irq[1]}, {15'h0, e[0]});
      wreg(sc1, {4'h4, e[1:0], 2'h0});
      ev_lvl <= 1'b0;
      repeat (8) @(posedge clk);
      chk({15'h0, channel_irq[1]}, {15'h0, e[1]});
    end
    wreg(sc1, 8'h4c);
    wreg(tsc, 8'h08);
    debug_active <= 1'b1;
    rreg(cnl, v);
    rreg(cnl, w);
    chk({8'h00, w}, {8'h00, v});
    rreg(cnh, w);
    c = {w, v};
    ev_lvl <= 1'b1;
    repeat (8) @(posedge clk);
    wreg(vl1, 8'hff);
    rd16(vh1, p);
    chk(p, c);
    chk({15'h0, channel_irq[1]}, 16'h1);
    debug_active <= 1'b0;
    rreg(vh1, w);
    ev_lvl <= 1'b0;
    repeat (8) @(posedge clk);
    rreg(vl1, v);
    chk({8'h00, v}, {8'h00, c[7:0]});
    rd16(vh1, p);
    rreg(vh1, w);
    ev_lvl <= 1'b1;
    repeat (8) @(posedge clk);
    wreg(sc1, 8'h4c);
    rreg(vl1, v);
    chk({15'h0, v != p[7:0]}, 16'h1);
    wreg(tsc, 8'h00);
  endtask
  task automatic t_modes();
    logic [15:0] p;
    wreg(sc1, 8'h54);
    wreg(vh1, 8'h12);
    wreg(vl1, 8'h34);
    ev_lvl <= 1'b0;
    repeat (8) @(posedge clk);
    ev_lvl <= 1'b1;
    repeat (8) @(posedge clk);
    rd16(vh1, p);
    chk(p, 16'h1234);
    chk({15'h0, channel_irq[1]}, 16'h0000);
    wreg(tsc, 8'h20);
    wreg(sc1, 8'h44);
    ev_lvl <= 1'b0;
    repeat (8) @(posedge clk);
    ev_lvl <= 1'b1;
    repeat (8) @(posedge clk);
    rd16(vh1, p);
    chk(p, 16'h1234);
    chk({15'h0, channel_irq[1]}, 16'h0000);
    wreg(tsc, 8'h00);
  endtask
  task automatic t_rerun();
    logic [7:0] v;
    wreg(mdl, 8'h02);
    wreg(cnh, 8'h00);
    wreg(sc1, 8'h4c);
    wreg(tsc, 8'h48);
    ev_lvl <= 1'b0;
    repeat (8) @(posedge clk);
    chk({14'h0, overflow_irq, channel_irq[1]}, 16'h0003);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk({14'h0, overflow_irq, channel_irq[1]}, 16'h0000);
    rreg(tsc, v);
    chk({8'h00, v}, 16'h0000);
    rreg(sc1, v);
    chk({8'h00, v}, 16'h0000);
    rreg(mdl, v);
    chk({8'h00, v}, 16'h0000);
    rreg(vl1, v);
    chk({8'h00, v}, 16'h0000);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    xtal_half_clk = 1'b0;
    forever
    begin
      repeat (4) @(posedge clk);
      xtal_half_clk <= ~xtal_half_clk;
    end
  end
  initial
  begin
    err_count = 0;
    n_checks = 0;
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    fll_engaged = 1'b0;
    debug_active = 1'b0;
    ext_run = 1'b0;
    ev_lvl = 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_sources();
    t_stop();
    t_overflow();
    t_center();
    t_capture();
    t_modes();
    t_rerun();
    finish_test();
  end
endmodule // tb
